// ===== src/lgc_top.sv
// three-input logic block: value inputs, inversion, six operations
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module lgc_top (
  input  wire logic                             mclk_i,
  input  wire logic                             nrst_i,
  input  wire logic                             scan_i,
  input  wire logic signed [lgc_pkg::VAL_W-1:0] val_a_i,
  input  wire logic signed [lgc_pkg::VAL_W-1:0] val_b_i,
  input  wire logic signed [lgc_pkg::VAL_W-1:0] val_c_i,
  input  wire logic        [lgc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic        [lgc_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                             wr_i,
  input  wire logic                             rd_i,
  output logic             [lgc_pkg::DATA_W-1:0] rdata_o,
  output logic             [lgc_pkg::SRC_W-1:0]  src_a_o,
  output logic             [lgc_pkg::SRC_W-1:0]  src_b_o,
  output logic             [lgc_pkg::SRC_W-1:0]  src_c_o,
  output logic signed      [lgc_pkg::VAL_W-1:0]  out_o
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // evaluate one operation over the connected levels only
  function automatic logic lgc_eval(input logic [2:0] op,
                                    input logic [2:0] lv,
                                    input logic [2:0] cn);
    logic used_any;
    logic or_r;
    logic and_r;
    logic xor_r;
    logic res;
    used_any = |cn;
    or_r     = |(lv & cn);
    and_r    = used_any && ((lv & cn) == cn);
    xor_r    = ^(lv & cn);
    case (op)
      lgc_pkg::OP_OR:   res = or_r;
      lgc_pkg::OP_AND:  res = and_r;
      lgc_pkg::OP_XOR:  res = xor_r;
      lgc_pkg::OP_NOR:  res = !or_r;
      lgc_pkg::OP_NAND: res = !and_r;
      lgc_pkg::OP_NXOR: res = !xor_r;
      default:          res = or_r;
    endcase
    return res;
  endfunction

  // true when a written code names one of the six operations
  function automatic logic lgc_op_ok(input logic [lgc_pkg::DATA_W-1:0] d);
    return d <= {5'h00, lgc_pkg::OP_NXOR};
  endfunction

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  lgc_pkg::lgc_op_t op_q;
  logic [2:0]       inv_q;
  logic [2:0]       conn;
  logic [2:0]       lvl_d;
  logic [2:0]       lvl_q;
  logic [2:0]       lv_x;
  logic             res_d;
  logic             res_q;

  // source addresses; the configurer keeps them in the legal ranges,
  // the block only stores them and tests them against zero
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_a_o <= lgc_pkg::SRC_RST;
      src_b_o <= lgc_pkg::SRC_RST;
      src_c_o <= lgc_pkg::SRC_RST;
    end else if (wr_i) begin
      case (addr_i)
        lgc_pkg::REG_SRC_A: src_a_o <= wdata_i;
        lgc_pkg::REG_SRC_B: src_b_o <= wdata_i;
        lgc_pkg::REG_SRC_C: src_c_o <= wdata_i;
        default: ;
      endcase
    end
  end

  // operation select; an unknown code is dropped so that the block
  // always runs one of the six defined operations
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_q <= lgc_pkg::OP_RST;
    end else if (wr_i && addr_i == lgc_pkg::REG_OP && lgc_op_ok(wdata_i)) begin
      op_q <= lgc_pkg::lgc_op_t'(wdata_i[2:0]);
    end
  end

  // inversion mask
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inv_q <= lgc_pkg::INV_RST;
    end else if (wr_i && addr_i == lgc_pkg::REG_INV) begin
      inv_q <= wdata_i[2:0];
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  // read data stand for exactly one cycle; unmapped offsets read zero
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        lgc_pkg::REG_SRC_A:  rdata_o <= src_a_o;
        lgc_pkg::REG_SRC_B:  rdata_o <= src_b_o;
        lgc_pkg::REG_SRC_C:  rdata_o <= src_c_o;
        lgc_pkg::REG_OP:     rdata_o <= {5'h00, op_q};
        lgc_pkg::REG_INV:    rdata_o <= {5'h00, inv_q};
        lgc_pkg::REG_STATUS: rdata_o <= {4'h0, res_q, lvl_q};
        default:             rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // ****************************************************************
  // input conversion
  // ****************************************************************
  // a source address of zero means nothing is wired to that input
  assign conn[0] = (src_a_o != lgc_pkg::SRC_NONE);
  assign conn[1] = (src_b_o != lgc_pkg::SRC_NONE);
  assign conn[2] = (src_c_o != lgc_pkg::SRC_NONE);

  lgc_hyst u_hyst_a (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .scan_i  (scan_i),
    .val_i   (val_a_i),
    .lvl_d_o (lvl_d[0]),
    .lvl_q_o (lvl_q[0])
  );

  lgc_hyst u_hyst_b (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .scan_i  (scan_i),
    .val_i   (val_b_i),
    .lvl_d_o (lvl_d[1]),
    .lvl_q_o (lvl_q[1])
  );

  lgc_hyst u_hyst_c (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .scan_i  (scan_i),
    .val_i   (val_c_i),
    .lvl_d_o (lvl_d[2]),
    .lvl_q_o (lvl_q[2])
  );

  // ****************************************************************
  // inversion and evaluation
  // ****************************************************************
  // the new levels are used directly, so the output of a scan already
  // reflects that scan's values and not the previous ones
  assign lv_x  = lvl_d ^ inv_q;
  assign res_d = lgc_eval(op_q, lv_x, conn);

  // result and analog output move together, only on a scan
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_q <= 1'b0;
      out_o <= lgc_pkg::OUT_ZERO;
    end else if (scan_i) begin
      res_q <= res_d;
      out_o <= res_d ? lgc_pkg::OUT_FULL : lgc_pkg::OUT_ZERO;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // all checks sample on the block clock and sleep during reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // a scan with only input A wired
  sequence s_scan_single_a;
    scan_i && conn == 3'b001;
  endsequence

  // a scan with all three inputs wired
  sequence s_scan_all;
    scan_i && conn == 3'b111;
  endsequence

  // a scan with only B and C wired
  sequence s_scan_bc;
    scan_i && conn == 3'b110;
  endsequence

  // a scan with no input wired at all
  sequence s_scan_none;
    scan_i && conn == 3'b000;
  endsequence

  // a write of a legal operation code
  sequence s_op_write;
    wr_i && addr_i == lgc_pkg::REG_OP && lgc_op_ok(wdata_i);
  endsequence

  // a write of a code beyond the six operations
  sequence s_op_bad_write;
    wr_i && addr_i == lgc_pkg::REG_OP && !lgc_op_ok(wdata_i);
  endsequence

  // a write of the inversion mask
  sequence s_inv_write;
    wr_i && addr_i == lgc_pkg::REG_INV;
  endsequence

  // a read of the status word
  sequence s_stat_read;
    rd_i && addr_i == lgc_pkg::REG_STATUS;
  endsequence

  // the output never takes an intermediate value
  a_out_binary : assert property (
    out_o == lgc_pkg::OUT_ZERO || out_o == lgc_pkg::OUT_FULL)
    else $error("output is neither 0 nor 100 percent");

  // a scan loads the output from that same scan's result
  a_out_scan : assert property (
    scan_i |=> out_o == ($past(res_d) ? lgc_pkg::OUT_FULL
                                      : lgc_pkg::OUT_ZERO))
    else $error("output does not follow the scan result");

  // between scans the output and the held levels are frozen
  a_out_hold : assert property (
    !scan_i |=> $stable(out_o) && $stable(lvl_q))
    else $error("output or levels moved without a scan");

  // status result bit and analog output move together
  a_res_match : assert property (
    res_q == (out_o == lgc_pkg::OUT_FULL))
    else $error("result bit and output disagree");

  // one wired input passes straight through or, and, xor
  a_single_pass : assert property (
    s_scan_single_a ##0 (op_q == lgc_pkg::OP_OR || op_q == lgc_pkg::OP_AND
                         || op_q == lgc_pkg::OP_XOR)
    |=> (out_o == lgc_pkg::OUT_FULL) == $past(lv_x[0]))
    else $error("single input not passed through");

  // three wired inputs: or and and against plain reductions
  a_all_or : assert property (
    s_scan_all ##0 (op_q == lgc_pkg::OP_OR)
    |=> (out_o == lgc_pkg::OUT_FULL) == $past(|lv_x))
    else $error("or of three inputs wrong");

  a_all_and : assert property (
    s_scan_all ##0 (op_q == lgc_pkg::OP_AND)
    |=> (out_o == lgc_pkg::OUT_FULL) == $past(&lv_x))
    else $error("and of three inputs wrong");

  // three wired inputs: xor is odd parity
  a_all_xor : assert property (
    s_scan_all ##0 (op_q == lgc_pkg::OP_XOR)
    |=> (out_o == lgc_pkg::OUT_FULL) == $past(^lv_x))
    else $error("xor of three inputs wrong");

  // three wired inputs: nand is the complement of and
  a_all_nand : assert property (
    s_scan_all ##0 (op_q == lgc_pkg::OP_NAND)
    |=> (out_o == lgc_pkg::OUT_FULL) != $past(&lv_x))
    else $error("nand of three inputs wrong");

  // nothing wired: the negated operations nor, nand and nxor give one
  a_none_neg : assert property (
    s_scan_none ##0 (op_q == lgc_pkg::OP_NOR || op_q == lgc_pkg::OP_NAND
                     || op_q == lgc_pkg::OP_NXOR)
    |=> out_o == lgc_pkg::OUT_FULL)
    else $error("negated operation with no input not one");

  // an unwired C cannot spoil an and of A and B
  a_unconn_skip : assert property (
    scan_i && !conn[2] && conn[1:0] == 2'b11 && op_q == lgc_pkg::OP_AND
    && lv_x[1:0] == 2'b11 |=> out_o == lgc_pkg::OUT_FULL)
    else $error("unwired input took part in evaluation");

  // input A unwired: or is decided by B and C alone
  a_bc_or : assert property (
    s_scan_bc ##0 (op_q == lgc_pkg::OP_OR)
    |=> (out_o == lgc_pkg::OUT_FULL) == $past(lv_x[1] | lv_x[2]))
    else $error("unwired input A changed the or result");

  // each negated operation is the complement of its plain partner
  a_comp_pair : assert property (
    lgc_eval(lgc_pkg::OP_NOR, lv_x, conn)
      != lgc_eval(lgc_pkg::OP_OR, lv_x, conn)
    && lgc_eval(lgc_pkg::OP_NAND, lv_x, conn)
      != lgc_eval(lgc_pkg::OP_AND, lv_x, conn)
    && lgc_eval(lgc_pkg::OP_NXOR, lv_x, conn)
      != lgc_eval(lgc_pkg::OP_XOR, lv_x, conn))
    else $error("negated operation not the complement");

  // mask bit 0 flips input A ahead of the operation
  a_inv_apply : assert property (
    s_scan_single_a ##0 (op_q == lgc_pkg::OP_OR && inv_q[0])
    |=> (out_o == lgc_pkg::OUT_FULL) != $past(lvl_d[0]))
    else $error("inversion of input A not applied");

  // a zero mask leaves the level as converted
  a_inv_none : assert property (
    s_scan_single_a ##0 (op_q == lgc_pkg::OP_OR && inv_q == 3'h0)
    |=> (out_o == lgc_pkg::OUT_FULL) == $past(lvl_d[0]))
    else $error("zero mask altered input A");

  // a legal code is stored at the write edge
  a_op_write : assert property (
    s_op_write |=> op_q == $past(wdata_i[2:0]))
    else $error("operation code not stored");

  // codes above five are dropped, the old operation stays
  a_op_refuse : assert property (
    s_op_bad_write |=> $stable(op_q))
    else $error("illegal operation code was stored");

  // the mask keeps the low three bits of the write
  a_inv_write : assert property (
    s_inv_write |=> inv_q == $past(wdata_i[2:0]))
    else $error("inversion mask not stored");

  // read data stand one cycle only and are zero otherwise
  a_rd_idle : assert property (
    !rd_i |=> rdata_o == '0)
    else $error("read data present without a read");

  // a status read returns the word as it stood at the read edge
  a_stat_read : assert property (
    s_stat_read |=> rdata_o == {4'h0, $past(res_q), $past(lvl_q)}
                    ##1 (rdata_o == '0 || $past(rd_i)))
    else $error("status read wrong or not one cycle");

endmodule

// ===== src/lgc_pkg.sv
// constants and types shared by the three-input logic block
package lgc_pkg;

  // ****************************************************************
  // data widths
  // ****************************************************************
  localparam int VAL_W  = 16;  // signed value, 0.01 % per lsb
  localparam int ADDR_W = 8;   // register address width
  localparam int DATA_W = 8;   // register data width
  localparam int SRC_W  = 8;   // source address width

  // ****************************************************************
  // value thresholds and output levels, 0.01 % units
  // ****************************************************************
  localparam logic signed [VAL_W-1:0] THR_LO   = 16'sh1b58; // 70.00 %
  localparam logic signed [VAL_W-1:0] THR_HI   = 16'sh1f40; // 80.00 %
  localparam logic signed [VAL_W-1:0] OUT_FULL = 16'sh2710; // 100.00 %
  localparam logic signed [VAL_W-1:0] OUT_ZERO = 16'sh0000; // 0.00 %

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_SRC_A  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SRC_B  = 8'h01;
  localparam logic [ADDR_W-1:0] REG_SRC_C  = 8'h02;
  localparam logic [ADDR_W-1:0] REG_OP     = 8'h03;
  localparam logic [ADDR_W-1:0] REG_INV    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h05;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int STAT_RES_BIT = 3;  // status: bits 2:0 levels, bit 3 result
  localparam logic [SRC_W-1:0] SRC_NONE = 8'h00;  // address 0: no source
  localparam logic [SRC_W-1:0] SRC_RST  = 8'h00;
  localparam logic [2:0]       INV_RST  = 3'h0;

  // ****************************************************************
  // operation codes
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_OR   = 3'b000,
    OP_AND  = 3'b001,
    OP_XOR  = 3'b010,
    OP_NOR  = 3'b011,
    OP_NAND = 3'b100,
    OP_NXOR = 3'b101
  } lgc_op_t;

  localparam lgc_op_t OP_RST = OP_OR;

endpackage

// ===== src/lgc_hyst.sv
// one input's value-to-level conversion with hysteresis
`timescale 1ns/1ps
module lgc_hyst (
  input  wire logic                           mclk_i,
  input  wire logic                           nrst_i,
  input  wire logic                           scan_i,
  input  wire logic signed [lgc_pkg::VAL_W-1:0] val_i,
  output logic                                lvl_d_o,
  output logic                                lvl_q_o
);

  // ****************************************************************
  // level decision
  // ****************************************************************
  // inside the band the old level stays, so a noisy value near one
  // threshold cannot make the level chatter
  always_comb begin
    if (val_i < lgc_pkg::THR_LO) begin
      lvl_d_o = 1'b0;
    end else if (val_i > lgc_pkg::THR_HI) begin
      lvl_d_o = 1'b1;
    end else begin
      lvl_d_o = lvl_q_o;
    end
  end

  // held level, refreshed only on a scan
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_q_o <= 1'b0;
    end else if (scan_i) begin
      lvl_q_o <= lvl_d_o;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_hyst_low : assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    scan_i && (val_i < lgc_pkg::THR_LO) |=> !lvl_q_o)
    else $error("level not zero below lower threshold");

  a_hyst_high : assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    scan_i && (val_i > lgc_pkg::THR_HI) |=> lvl_q_o)
    else $error("level not one above upper threshold");

  a_hyst_band : assert property (
    @(posedge mclk_i) disable iff (!nrst_i)
    scan_i && (val_i >= lgc_pkg::THR_LO) && (val_i <= lgc_pkg::THR_HI)
    |=> $stable(lvl_q_o))
    else $error("level changed inside the hysteresis band");

endmodule

// ===== verif/lgc_peer.sv
// peer function blocks: value table addressed by the block's source selects
`timescale 1ns/1ps
module lgc_peer (
  input  wire logic               mclk_i,
  input  wire logic        [7:0]  src_a_i,
  input  wire logic        [7:0]  src_b_i,
  input  wire logic        [7:0]  src_c_i,
  output logic signed      [15:0] val_a_o,
  output logic signed      [15:0] val_b_o,
  output logic signed      [15:0] val_c_o
);
  logic signed [15:0] tbl [256];
  logic        [15:0] junk_q = 16'h0a5c;

  // an unconnected input sees a moving pattern, never a stale value
  always_ff @(posedge mclk_i) begin
    junk_q <= junk_q + 16'h1357;
  end

  // source address zero selects nothing; others read the peer table
  assign val_a_o = (src_a_i == lgc_pkg::SRC_NONE) ? junk_q : tbl[src_a_i];
  assign val_b_o = (src_b_i == lgc_pkg::SRC_NONE) ? junk_q : tbl[src_b_i];
  assign val_c_o = (src_c_i == lgc_pkg::SRC_NONE) ? junk_q : tbl[src_c_i];

  // the bench loads a peer block's output value
  task automatic put(input int a, input int v);
    tbl[a[7:0]] <= v[15:0];
  endtask
endmodule

// ===== verif/lgc_top_tb.sv
// self-checking bench for the three-input logic block
`timescale 1ns/1ps
module lgc_top_tb;
  // ****************************************************************
  // signals and model state
  // ****************************************************************
  logic               mclk_i  = 1'b0;
  logic               nrst_i  = 1'b0;
  logic               scan_i  = 1'b0;
  logic               wr_i    = 1'b0;
  logic               rd_i    = 1'b0;
  logic        [7:0]  addr_i  = 8'h00;
  logic        [7:0]  wdata_i = 8'h00;
  logic        [7:0]  rdata_o;
  logic        [7:0]  sa, sb, sc;
  logic signed [15:0] va, vb, vc;
  logic signed [15:0] out_o;
  int n_errors = 0;
  int total_checks = 0;
  int lv [3];
  int src [3];
  int tab [8] = '{-100, 0, 6999, 7000, 7500, 8000, 8001, 10000};
  int op, inv, res, it, k, d;

  always #2.5 mclk_i = ~mclk_i;

  lgc_top u_lgc_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .scan_i(scan_i),
    .val_a_i(va), .val_b_i(vb), .val_c_i(vc), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .src_a_o(sa), .src_b_o(sb), .src_c_o(sc), .out_o(out_o));

  lgc_peer u_lgc_peer (.mclk_i(mclk_i),
    .src_a_i(sa), .src_b_i(sb), .src_c_i(sc),
    .val_a_o(va), .val_b_o(vb), .val_c_o(vc));

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // strobe released one edge before the task returns, so no double drive
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    addr_i  <= a;
    wdata_i <= dat;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    check({8'h00, rdata_o}, {8'h00, exp});
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // reset and confirm every default except that of source B
  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    lv  = '{0, 0, 0};
    src = '{0, 0, 0};
    op  = 0;
    inv = 0;
    check(out_o, lgc_pkg::OUT_ZERO);
    chk_rd(lgc_pkg::REG_OP, 8'h00);
    chk_rd(lgc_pkg::REG_INV, 8'h00);
    chk_rd(lgc_pkg::REG_SRC_A, 8'h00);
    chk_rd(lgc_pkg::REG_SRC_C, 8'h00);
    chk_rd(lgc_pkg::REG_STATUS, 8'h00);
  endtask

  // one scan: model works from the values the peer presents at the edge
  task automatic scan();
    int v [3];
    int n, ones, j, st;
    scan_i <= 1'b1;
    @(posedge mclk_i);
    scan_i <= 1'b0;
    v[0] = va;
    v[1] = vb;
    v[2] = vc;
    n = 0;
    ones = 0;
    for (j = 0; j < 3; j++) begin
      // inside the band the held level stays
      if (v[j] < lgc_pkg::THR_LO) lv[j] = 0;
      else if (v[j] > lgc_pkg::THR_HI) lv[j] = 1;
      if (src[j] != 0) begin
        n++;
        ones += lv[j] ^ ((inv >> j) & 1);
      end
    end
    case (op % 3)
      0: res = (ones > 0);
      1: res = (n > 0) && (ones == n);
      default: res = ones % 2;
    endcase
    if (op >= 3) res = 1 - res;
    st = res * 8 + lv[2] * 4 + lv[1] * 2 + lv[0];
    @(posedge mclk_i);
    check(out_o, res ? lgc_pkg::OUT_FULL : lgc_pkg::OUT_ZERO);
    chk_rd(lgc_pkg::REG_STATUS, st[7:0]);
    check(out_o, res ? lgc_pkg::OUT_FULL : lgc_pkg::OUT_ZERO);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(18));
    do_reset();
    for (it = 0; it < 300; it++) begin
      for (k = 0; k < 3; k++) begin
        if ($urandom_range(0, 2) == 0) src[k] = 0;
        else if ($urandom_range(0, 1)) src[k] = $urandom_range(1, 170);
        else src[k] = $urandom_range(225, 240);
        wr(k[7:0], src[k][7:0]);
        d = ($urandom_range(0, 8) == 8) ? $urandom_range(0, 10200)
                                        : tab[$urandom_range(0, 7)];
        u_lgc_peer.put(src[k], d);
      end
      check({8'h00, sa}, src[0][15:0]);
      check({8'h00, sb}, src[1][15:0]);
      check({8'h00, sc}, src[2][15:0]);
      d = $urandom_range(0, 7);
      wr(lgc_pkg::REG_OP, d[7:0]);
      if (d <= 5) op = d;
      d = $urandom_range(0, 255);
      wr(lgc_pkg::REG_INV, d[7:0]);
      inv = d & 7;
      if (it % 16 == 0) begin
        chk_rd(lgc_pkg::REG_OP, op[7:0]);
        chk_rd(lgc_pkg::REG_INV, inv[7:0]);
        chk_rd(lgc_pkg::REG_SRC_B, src[1][7:0]);
        d = $urandom_range(6, 255);
        chk_rd(d[7:0], 8'h00);
        wr(lgc_pkg::REG_STATUS, 8'hff);
      end
      scan();
      if (it == 150) do_reset();
    end
    complete_run();
  end
endmodule
